// File: core/csr_delta_hold.sv
/*
  Holding register for the averaged frequency difference, with freeze and clear.
  Assumes the measuring logic shares the clock and strobes each new average.
*/
module csr_delta_hold
  import csr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        update,
  input  wire logic [15:0] sample,
  input  wire logic        freeze,
  input  wire logic        clear,
  output logic      [15:0] value
);
  logic [15:0] value_reg;   // Held difference, two's complement.
  logic [15:0] value_next;  // Next held difference.

  // A clear beats a fresh sample so that software sees zero afterwards.
  always_comb
  begin
    value_next = value_reg;
    if (clear)
    begin
      value_next = RST_DELTA;
    end
    else if (update && !freeze)
    begin
      value_next = sample;
    end
  end

  // Registers the held value.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      value_reg <= RST_DELTA;
    else
      value_reg <= value_next;
  end

  assign value = value_reg;

  a_freeze_holds: assert property (@(posedge clk) disable iff (!nrst)
    freeze && !clear |=> $stable(value))
    else $error("delta changed while frozen");
  a_clear_zeroes: assert property (@(posedge clk) disable iff (!nrst)
    clear |=> value == 16'h0000)
    else $error("delta not zero after clear");
  a_update_loads: assert property (@(posedge clk) disable iff (!nrst)
    update && !freeze && !clear |=> value == $past(sample))
    else $error("delta missed an update");
endmodule : csr_delta_hold

// File: core/csr_pkg.sv
/*
  Shared constants for the clock synthesizer upper control bytes (3 to 10).
  Assumes a byte-wide register port driven by an SMBus engine in the same clock domain.
*/
package csr_pkg;
  // Byte offsets of the registers held in this block.
  localparam logic [7:0] OFS_PFT_CTRL   = 8'h03;
  localparam logic [7:0] OFS_DELTA_LO   = 8'h04;
  localparam logic [7:0] OFS_DELTA_HI   = 8'h05;
  localparam logic [7:0] OFS_SPREAD     = 8'h06;
  localparam logic [7:0] OFS_VENDOR_REV = 8'h08;
  localparam logic [7:0] OFS_DEVICE_ID  = 8'h09;
  localparam logic [7:0] OFS_COUNT      = 8'h0A;
  // Field positions in the platform-time control byte.
  localparam int BIT_LOST   = 7;
  localparam int BIT_FREEZE = 6;
  localparam int BIT_CLEAR  = 5;
  // Field positions in the spread-spectrum control byte.
  localparam int BIT_PIN_RB_LO = 4;
  localparam int BIT_REF_SEL   = 3;
  localparam int BIT_SW_CTRL   = 2;
  // Width of the block-read byte count field.
  localparam int COUNT_W = 6;
  // Reset values.
  localparam logic [5:0]  RST_COUNT = 6'h08;
  localparam logic [15:0] RST_DELTA = 16'h0000;
  // Spread-spectrum codes.
  localparam logic [1:0] SPREAD_OFF = 2'h0;
  // Block-read sequencer states.
  typedef enum logic [1:0]
  {
    CSR_IDLE   = 2'b01,
    CSR_STREAM = 2'b10
  } csr_state_e;
endpackage : csr_pkg

// File: core/csr_regs.sv
/*
  Control bytes 3 to 10: platform-time monitor, spread control, identity, byte count.
  Assumes an SMBus engine on CLK_SYS presents byte accesses and block-read steps.
*/
// Summary of operation
// - Byte 3 bit 7 shows lost indicator level.
// - Freeze bit stops difference byte updates.
// - Writing clear bit zeroes both difference bytes.
// - Byte 4 shows difference low eight bits.
// - Byte 5 shows high bits and sign.
// - Byte 6 bits 5:4 read spread pin.
// - Byte 6 bit 3 picks PLL reference.
// - Software spread select, latched from pin.
// - Byte 8 shows revision and vendor codes.
// - Byte 9 shows fixed device code.
// - Byte 10 count, default eight, writable.
// - Block read sends count then bytes.
module csr_regs
  import csr_pkg::*;
#(
  parameter logic [3:0] REV_CODE    = 4'h0,  // First silicon reads zero.
  parameter logic [3:0] VENDOR_CODE = 4'hA,  // Arbitrary value.
  parameter logic [7:0] DEVICE_CODE = 8'h5C  // Arbitrary value.
)
(
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WE,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RE,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        BLK_START,
  input  wire logic        BLK_NEXT,
  output logic      [7:0]  BLK_DATA,
  output logic             BLK_ACTIVE,
  input  wire logic        PLATFORM_TIME_LOST_N,
  input  wire logic [1:0]  SPREAD_ENABLE_PIN,
  input  wire logic        DELTA_STROBE,
  input  wire logic [15:0] DELTA_SAMPLE,
  output logic      [1:0]  SPREAD_MODE,
  output logic             PLL_REF_SEL,
  output logic      [5:0]  BYTE_COUNT
);
  // Pin synchronisers; the first stage feeds only the second.
  logic       lost_s1_reg;
  logic       lost_s2_reg;
  logic [1:0] pin_s1_reg;
  logic [1:0] pin_s2_reg;

  // Software-visible control state.
  logic             freeze_reg;    // Stops difference updates.
  logic             freeze_next;
  logic             clear_reg;     // Pending clear, self-returning.
  logic             clear_next;
  logic             ref_sel_reg;   // PLL reference choice.
  logic             ref_sel_next;
  logic             sw_ctrl_reg;   // Software owns the spread setting.
  logic             sw_ctrl_next;
  logic [1:0]       sel_reg;       // Software spread selection.
  logic [1:0]       sel_next;
  logic             latched_reg;   // Power-up pin capture done.
  logic             latched_next;
  logic [1:0]       settle_reg;    // Fills with ones as the pin synchroniser fills.
  logic [1:0]       settle_next;
  logic [COUNT_W-1:0] count_reg;   // Block-read byte count.
  logic [COUNT_W-1:0] count_next;
  logic [7:0]       rdata_reg;
  logic [7:0]       rdata_next;

  // Block-read sequencer state.
  csr_state_e         state_reg;
  csr_state_e         state_next;
  logic [7:0]         ptr_reg;
  logic [7:0]         ptr_next;
  logic [COUNT_W-1:0] left_reg;
  logic [COUNT_W-1:0] left_next;
  logic [7:0]         bdata_reg;
  logic [7:0]         bdata_next;

  logic [15:0] delta;  // Held frequency difference.
  logic        wr_hit;

  // Difference holder with freeze and clear.
  csr_delta_hold u_delta
  (
    .clk    (CLK_SYS),
    .nrst   (NRST),
    .update (DELTA_STROBE),
    .sample (DELTA_SAMPLE),
    .freeze (freeze_reg),
    .clear  (clear_reg),
    .value  (delta)
  );

  // Byte image of any offset; offsets outside this block read as zero.
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      OFS_PFT_CTRL:
      begin
        d[BIT_LOST]   = lost_s2_reg;
        d[BIT_FREEZE] = freeze_reg;
        d[BIT_CLEAR]  = clear_reg;
      end
      OFS_DELTA_LO:   d = delta[7:0];
      OFS_DELTA_HI:   d = delta[15:8];
      OFS_SPREAD:
      begin
        d[BIT_PIN_RB_LO+:2] = pin_s2_reg;
        d[BIT_REF_SEL]      = ref_sel_reg;
        d[BIT_SW_CTRL]      = sw_ctrl_reg;
        d[1:0]              = sel_reg;
      end
      OFS_VENDOR_REV: d = {REV_CODE, VENDOR_CODE};
      OFS_DEVICE_ID:  d = DEVICE_CODE;
      OFS_COUNT:      d = {2'h0, count_reg};
      default:        d = 8'h00;
    endcase
    return d;
  endfunction : read_byte

  // Two flip-flops on every pin before logic looks at it.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      // The lost pin idles high, so reset shows the idle level.
      lost_s1_reg <= 1'b1;
      lost_s2_reg <= 1'b1;
      pin_s1_reg  <= SPREAD_OFF;
      pin_s2_reg  <= SPREAD_OFF;
    end
    else
    begin
      lost_s1_reg <= PLATFORM_TIME_LOST_N;
      lost_s2_reg <= lost_s1_reg;
      pin_s1_reg  <= SPREAD_ENABLE_PIN;
      pin_s2_reg  <= pin_s1_reg;
    end
  end

  assign wr_hit = REG_WE && !BLK_ACTIVE;

  // Register writes; only writable fields are touched.
  always_comb
  begin
    freeze_next  = freeze_reg;
    clear_next   = 1'b0;
    ref_sel_next = ref_sel_reg;
    sw_ctrl_next = sw_ctrl_reg;
    sel_next     = sel_reg;
    latched_next = latched_reg | settle_reg[1];
    settle_next  = {settle_reg[0], 1'b1};
    count_next   = count_reg;
    rdata_next   = rdata_reg;
    // The pin is loaded once, only when both synchroniser stages hold it.
    // Loading earlier would capture the synchroniser's reset value instead.
    if (!latched_reg && settle_reg[1])
    begin
      sel_next = pin_s2_reg;
    end
    if (wr_hit)
    begin
      unique case (REG_ADDR)
        OFS_PFT_CTRL:
        begin
          freeze_next = REG_WDATA[BIT_FREEZE];
          clear_next  = REG_WDATA[BIT_CLEAR];
        end
        OFS_SPREAD:
        begin
          ref_sel_next = REG_WDATA[BIT_REF_SEL];
          sw_ctrl_next = REG_WDATA[BIT_SW_CTRL];
          sel_next     = REG_WDATA[1:0];
        end
        OFS_COUNT:    count_next = REG_WDATA[COUNT_W-1:0];
        default:      count_next = count_reg;
      endcase
    end
    if (REG_RE)
    begin
      rdata_next = read_byte(REG_ADDR);
    end
  end

  // Registers the control state.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      freeze_reg  <= 1'b0;
      clear_reg   <= 1'b0;
      ref_sel_reg <= 1'b0;
      sw_ctrl_reg <= 1'b0;
      sel_reg     <= SPREAD_OFF;
      latched_reg <= 1'b0;
      settle_reg  <= 2'b00;
      count_reg   <= RST_COUNT;
      rdata_reg   <= 8'h00;
    end
    else
    begin
      freeze_reg  <= freeze_next;
      clear_reg   <= clear_next;
      ref_sel_reg <= ref_sel_next;
      sw_ctrl_reg <= sw_ctrl_next;
      sel_reg     <= sel_next;
      latched_reg <= latched_next;
      settle_reg  <= settle_next;
      count_reg   <= count_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Block read: count byte first, then that many bytes from the offset.
  always_comb
  begin
    state_next = state_reg;
    ptr_next   = ptr_reg;
    left_next  = left_reg;
    bdata_next = bdata_reg;
    unique case (state_reg)
      CSR_IDLE:
      begin
        if (BLK_START)
        begin
          state_next = CSR_STREAM;
          ptr_next   = REG_ADDR;
          left_next  = count_reg;
          bdata_next = {2'h0, count_reg};
        end
      end
      CSR_STREAM:
      begin
        if (BLK_NEXT)
        begin
          if (left_reg == '0)
          begin
            state_next = CSR_IDLE;
          end
          else
          begin
            bdata_next = read_byte(ptr_reg);
            ptr_next   = ptr_reg + 8'h01;
            left_next  = left_reg - 1'b1;
          end
        end
      end
    endcase
  end

  // Registers the sequencer.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      state_reg <= CSR_IDLE;
      ptr_reg   <= 8'h00;
      left_reg  <= '0;
      bdata_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      ptr_reg   <= ptr_next;
      left_reg  <= left_next;
      bdata_reg <= bdata_next;
    end
  end

  // The pin rules unless software has taken control.
  assign SPREAD_MODE = sw_ctrl_reg ? sel_reg : pin_s2_reg;
  assign PLL_REF_SEL = ref_sel_reg;
  assign BYTE_COUNT  = count_reg;
  assign REG_RDATA   = rdata_reg;
  assign BLK_DATA    = bdata_reg;
  assign BLK_ACTIVE  = (state_reg == CSR_STREAM);

  a_lost_readback: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    REG_RE && REG_ADDR == OFS_PFT_CTRL |=> REG_RDATA[BIT_LOST] == $past(lost_s2_reg))
    else $error("lost readback wrong");
  a_clear_self: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    clear_reg |=> !clear_reg || $past(wr_hit))
    else $error("clear bit stuck");
  a_id_fixed: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    REG_RE && REG_ADDR == OFS_DEVICE_ID |=> REG_RDATA == DEVICE_CODE)
    else $error("device code wrong");
  a_rev_fixed: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    REG_RE && REG_ADDR == OFS_VENDOR_REV |=> REG_RDATA == {REV_CODE, VENDOR_CODE})
    else $error("vendor byte wrong");
  a_count_write: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    wr_hit && REG_ADDR == OFS_COUNT |=> BYTE_COUNT == $past(REG_WDATA[5:0]))
    else $error("count not written");
  a_blk_first: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    BLK_START && !BLK_ACTIVE |=> BLK_ACTIVE && BLK_DATA == {2'h0, $past(BYTE_COUNT)})
    else $error("block read count byte wrong");
  a_spread_mode: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !sw_ctrl_reg |-> SPREAD_MODE == pin_s2_reg)
    else $error("pin not in control");
  a_pin_readback: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    REG_RE && REG_ADDR == OFS_SPREAD |=> REG_RDATA[5:4] == $past(pin_s2_reg))
    else $error("spread pin readback wrong");
  a_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    REG_RE && REG_ADDR == OFS_COUNT |=> REG_RDATA[7:6] == 2'h0)
    else $error("reserved bits not zero");
  c_block_read: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    BLK_ACTIVE ##1 !BLK_ACTIVE);
  c_clear_write: cover property (@(posedge CLK_SYS) disable iff (!NRST) clear_reg);
  c_sw_spread: cover property (@(posedge CLK_SYS) disable iff (!NRST) sw_ctrl_reg);
endmodule : csr_regs

// File: dv/csr_host.sv
/*
  Host-side model of the SMBus engine that reaches the control bytes.
  Assumes the register and block-read ports of csr_regs on the same clock.
*/
module csr_host
(
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr,
  output logic            we,
  output logic      [7:0] wdata,
  output logic            re,
  output logic            blk_start,
  output logic            blk_next
);
  timeunit 1ns;
  timeprecision 1ns;

  // Every request is launched 1 ns after an edge and held across the taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {addr, wdata, we} = {a, d, 1'b1};
    @(posedge clk);
    #1 we = 1'b0;
  endtask : wr

  // Read data is registered, so it is taken after the edge that accepted the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 {addr, re} = {a, 1'b1};
    @(posedge clk);
    #1 re = 1'b0;
    d = rdata;
  endtask : rd

  // Both halves are read under freeze so they come from one update.
  task automatic rd_delta(output logic [15:0] v);
    wr(8'h03, 8'h40);
    rd(8'h04, v[7:0]);
    rd(8'h05, v[15:8]);
    wr(8'h03, 8'h00);
  endtask : rd_delta

  // Mux select control goes up first, then the frequency select is written.
  task automatic mux_sel(input logic f);
    wr(8'h02, 8'h40);
    wr(8'h02, {f, 7'h40});
  endtask : mux_sel

  // One-cycle pulse on a block-read control; start also carries the begin offset.
  task automatic blk(input logic start, input logic [7:0] a);
    @(posedge clk);
    #1 {addr, blk_start, blk_next} = {a, start, !start};
    @(posedge clk);
    #1 {blk_start, blk_next} = 2'b00;
  endtask : blk

  // Idle levels at time zero.
  initial {addr, we, wdata, re, blk_start, blk_next} = '0;
endmodule : csr_host

// File: dv/tb_top.sv
/*
  Self-checking bench for the upper control bytes.
  Assumes csr_regs and csr_host; all inputs change 1 ns after a rising edge.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import csr_pkg::*;

  localparam logic [3:0] VEND = 4'h6;  // Arbitrary value.
  localparam logic [7:0] DEVC = 8'h3C; // Arbitrary value.

  logic        clk = 1'b0;   // 10 MHz system clock.
  logic        nrst = 1'b0;  // Active-low reset.
  logic        lost_n = 1'b1;
  logic [1:0]  pin = 2'b11;  // Held steady so the power-up latch sees -0.5%.
  logic        stb = 1'b0;
  logic [15:0] smp = '0;
  logic [7:0]  addr, wdata, rdata, bdata, v;
  logic        we, re, bst, bnx, bact, rsel;
  logic [1:0]  mode;
  logic [5:0]  cnt;
  logic [15:0] dv;
  int          n_errors = 0;
  int          n_tests = 0;

  // One row: write a byte, read it back, expect the value below.
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} csr_row_s;
  csr_row_s rows[8] = '{
    '{8'h09, 8'hFF, DEVC}, '{8'h08, 8'hFF, {4'h0, VEND}},
    '{8'h07, 8'hFF, 8'h00}, '{8'h0A, 8'hFF, 8'h3F},
    '{8'h0A, 8'h08, 8'h08}, '{8'h04, 8'hFF, 8'h00},
    '{8'h03, 8'h1F, 8'h80}, '{8'h06, 8'hFF, 8'h3F}};

  always #50 clk = ~clk;

  csr_regs #(.REV_CODE(4'h0), .VENDOR_CODE(VEND), .DEVICE_CODE(DEVC)) dut
  (
    .CLK_SYS(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WE(we), .REG_WDATA(wdata),
    .REG_RE(re), .REG_RDATA(rdata), .BLK_START(bst), .BLK_NEXT(bnx),
    .BLK_DATA(bdata), .BLK_ACTIVE(bact), .PLATFORM_TIME_LOST_N(lost_n),
    .SPREAD_ENABLE_PIN(pin), .DELTA_STROBE(stb), .DELTA_SAMPLE(smp),
    .SPREAD_MODE(mode), .PLL_REF_SEL(rsel), .BYTE_COUNT(cnt)
  );

  csr_host host
  (
    .clk(clk), .rdata(rdata), .addr(addr), .we(we), .wdata(wdata),
    .re(re), .blk_start(bst), .blk_next(bnx)
  );

  // Compares with case equality so an unknown never passes.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Reads a byte and compares it.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    check(v, e);
  endtask : rchk

  // Presents one new average for a single cycle.
  task automatic strobe(input logic [15:0] s);
    @(posedge clk);
    #1 {stb, smp} = {1'b1, s};
    @(posedge clk);
    #1 stb = 1'b0;
  endtask : strobe

  // The single place where the run ends.
  task automatic conclude();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Watchdog: the whole sequence needs well under 2000 cycles.
  initial
  begin
    #200000;
    n_errors++;
    conclude();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    // Reset values and the power-up latch of the pin code.
    rchk(8'h06, 8'h33);
    rchk(8'h0A, 8'h08);
    rchk(8'h04, 8'h00);
    check({2'h0, mode}, 8'h03);
    // Write then read back every table row.
    foreach (rows[i])
    begin
      host.wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    check({7'h0, rsel}, 8'h01);
    // Byte 2 lives outside this block, so it reads zero here.
    host.mux_sel(1'b1);
    rchk(8'h02, 8'h00);
    // Software select differs from the pin, then the pin takes over again.
    host.wr(8'h06, 8'h05);
    rchk(8'h06, 8'h35);
    check({2'h0, mode}, 8'h01);
    check({7'h0, rsel}, 8'h00);
    host.wr(8'h06, 8'h01);
    @(posedge clk);
    check({2'h0, mode}, 8'h03);
    // Live lost indicator through the synchroniser.
    #1 lost_n = 1'b0;
    repeat (3) @(posedge clk);
    rchk(8'h03, 8'h00);
    // Signed difference split over two bytes.
    strobe(16'h8123);
    host.rd_delta(dv);
    check(dv[7:0], 8'h23);
    check(dv[15:8], 8'h81);
    // Frozen: a new sample must not land.
    host.wr(8'h03, 8'h40);
    strobe(16'h1234);
    rchk(8'h04, 8'h23);
    host.wr(8'h03, 8'h00);
    strobe(16'h1234);
    rchk(8'h05, 8'h12);
    // Clear zeroes both bytes and the control drops by itself.
    host.wr(8'h03, 8'h20);
    repeat (2) @(posedge clk);
    rchk(8'h04, 8'h00);
    rchk(8'h05, 8'h00);
    rchk(8'h03, 8'h00);
    // Block read of three bytes from offset 8, count first.
    host.wr(8'h0A, 8'h03);
    @(posedge clk);
    check({2'h0, cnt}, 8'h03);
    host.blk(1'b1, 8'h08);
    check({7'h0, bact}, 8'h01);
    check(bdata, 8'h03);
    // A write during the block read is refused; byte 10 below still reads 3.
    host.wr(8'h0A, 8'h3F);
    host.blk(1'b0, 8'h00);
    check(bdata, {4'h0, VEND});
    host.blk(1'b0, 8'h00);
    check(bdata, DEVC);
    host.blk(1'b0, 8'h00);
    check(bdata, 8'h03);
    host.blk(1'b0, 8'h00);
    check({7'h0, bact}, 8'h00);
    // A second reset restores the count and latches the pin code again.
    @(posedge clk);
    #1 nrst = 1'b0;
    @(posedge clk);
    check({2'h0, cnt}, 8'h08);
    check({2'h0, mode}, 8'h00);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    rchk(8'h06, 8'h33);
    conclude();
  end
endmodule : tb_top
